// *** bench/cwb_cache_model.sv ***
// cwb_cache_model: behavioural cache memory port answering after a set latency
// assumes the bridge holds cache_req until it has sampled cache_ack
`timescale 1ns/100ps
module cwb_cache_model import cwb_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // cache memory port
    input wire logic cache_req,
    input wire logic cache_we,
    input wire logic [1:0] cache_half,
    input wire logic [ADDR_W-1:0] cache_addr,
    input wire logic [WIDE_W-1:0] cache_wdata,
    output logic cache_ack,
    output logic cache_err,
    output logic [WIDE_W-1:0] cache_rdata,
    // scenario control
    input wire logic [1:0] lat,
    input wire logic err_en
);
    logic [WIDE_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [WIDE_W-1:0] w;
    int cnt;
    // =====================================================================
    // one access per request; read lines toggle while nothing is answered
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cache_ack <= 1'b0;
            cache_err <= 1'b0;
            cache_rdata <= 32'h0;
            cnt <= 0;
        end else if (cache_req && !cache_ack && cnt >= lat) begin
            w = mem.exists(cache_addr) ? mem[cache_addr] : {~cache_addr[15:0], cache_addr[15:0]};
            if (cache_we && cache_half[0]) w[15:0] = cache_wdata[15:0];
            if (cache_we && cache_half[1]) w[31:16] = cache_wdata[31:16];
            if (cache_we && !err_en) mem[cache_addr] = w; // failed write leaves memory
            cache_ack <= 1'b1;
            cache_err <= err_en;
            cache_rdata <= w;
            cnt <= 0;
        end else begin
            cache_ack <= 1'b0;
            cache_err <= 1'b0;
            cache_rdata <= ~cache_rdata;
            cnt <= (cache_req && !cache_ack) ? cnt + 1 : 0;
        end
    end
endmodule : cwb_cache_model

// *** bench/tb.sv ***
// tb: self-checking bench for the cache width bridge
// assumes cwb_cache_model stands on the cache port; inputs move at falling edges
`timescale 1ns/100ps
module tb;
    import cwb_pkg::*;
    logic clk_sys, rst_n, dma_grant_in, hb_sel, ctl_req, ctl_write, ctl_last;
    logic ctl_status_clr, dma_grant_line, dma_request_line, sel_addr_ext, sel_csr3;
    logic ctl_ready, ctl_ack, ctl_rvalid, cache_req, cache_we, cache_ack, cache_err, err_en;
    logic [HB_ADDR_W-1:0] hb_addr;
    logic [ADDR_W-1:0] ctl_addr, cache_addr, ha;
    logic [NARROW_W-1:0] ctl_wdata, ctl_rdata, hd;
    logic [WIDE_W-1:0] cache_wdata, cache_rdata;
    logic [WIDE_W-1:0] sh [logic [ADDR_W-1:0]];
    logic [1:0] ctl_status, cache_half, lat, st_exp;
    logic hv;
    int error_cnt, total_checks;
    logic [23:0] cor [10] = '{24'h800100, 24'h800102, 24'h800106, 24'hC00108, 24'h000100,
        24'h000102, 24'h400108, 24'h40010A, 24'h800200, 24'hC00204};
    // =====================================================================
    // device and cache partner
    cwb_bridge i_dut (.clk_sys, .rst_n, .dma_grant_in, .dma_grant_line, .dma_request_line,
        .hb_sel, .hb_addr, .sel_addr_ext, .sel_csr3, .ctl_req, .ctl_write, .ctl_last,
        .ctl_addr, .ctl_wdata, .ctl_ready, .ctl_ack, .ctl_rvalid, .ctl_rdata,
        .ctl_status_clr, .ctl_status, .cache_req, .cache_we, .cache_half, .cache_addr,
        .cache_wdata, .cache_ack, .cache_err, .cache_rdata);
    cwb_cache_model i_cache (.clk_sys, .rst_n, .cache_req, .cache_we, .cache_half,
        .cache_addr, .cache_wdata, .cache_ack, .cache_err, .cache_rdata, .lat, .err_en);
    // 125 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // =====================================================================
    // compare, verdict and bounded wait
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task final_report;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    task wait_hi(input bit rv);
        int n;
        n = 0;
        while ((rv ? ctl_rvalid : ctl_ready) !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > 60) begin
                chk("wait", 1, 0);
                final_report();
            end
        end
    endtask : wait_hi
    // cache contents before any write: a pattern made from the word address
    function automatic logic [WIDE_W-1:0] fill(input logic [ADDR_W-1:0] a);
        fill = {~a[15:0], a[15:0]};
    endfunction : fill
    // =====================================================================
    // one controller word: expected cache cycle worked out from held state
    task op(input logic we, input logic [ADDR_W-1:0] a, input logic last);
        logic [ADDR_W-1:0] ca;
        logic [NARROW_W-1:0] d;
        logic [WIDE_W-1:0] w, m;
        logic [1:0] h;
        logic brd;
        ca = {a[ADDR_W-1:2], 2'h0};
        d = NARROW_W'($urandom);
        w = sh.exists(ca) ? sh[ca] : fill(ca);
        h = a[1] ? HALF_HI : HALF_LO;
        brd = 1'b0;
        if (a[1] && hv && ha == ca) begin
            h = HALF_BOTH;
            brd = !we;
        end else begin
            if (hv && we) st_exp[ERR_SEQ_BIT] = 1'b1; // held word dropped
            if (!a[1] && !last) h = we ? HALF_NONE : HALF_BOTH;
        end
        if (we && h[1]) w[31:16] = d;
        if (we && h[0]) w[15:0] = (h == HALF_BOTH) ? hd : d;
        if (we && !err_en) sh[ca] = w;
        m = {{16{h[1]}}, {16{h[0]}}};
        wait_hi(0);
        ctl_req = 1'b1;
        ctl_write = we;
        ctl_last = last;
        ctl_wdata = d;
        ctl_addr = a | ADDR_W'($urandom_range(0, 1));
        @(negedge clk_sys);
        ctl_req = 1'b0;
        chk("ctl_ack", we, ctl_ack);
        chk("cache_req", h != HALF_NONE && !brd, cache_req);
        if (cache_req === 1'b1) begin
            chk("cache_half", h, cache_half);
            chk("cache_addr", ca, cache_addr);
            chk("cache_we", we, cache_we);
            if (we) chk("cache_wdata", w & m, cache_wdata & m);
        end
        if (brd) chk("ctl_rvalid", 1, ctl_rvalid);
        if (!we) begin
            wait_hi(1);
            if (!err_en) chk("ctl_rdata", a[1] ? w[31:16] : w[15:0], ctl_rdata);
        end
        wait_hi(0);
        @(negedge clk_sys);
        if (err_en && h != HALF_NONE) st_exp[ERR_MEM_BIT] = 1'b1;
        chk("ctl_status", st_exp, ctl_status);
        hv = !a[1] && !last;
        ha = ca;
        hd = d;
    endtask : op
    // =====================================================================
    // reset, host bus, corner words, error path, then random transfers
    initial begin
        bit rw;
        int n;
        logic [ADDR_W-1:0] a0;
        {rst_n, dma_grant_in, hb_sel, ctl_req, ctl_write, ctl_last} = '0;
        {ctl_status_clr, err_en, hv} = '0;
        hb_addr = '0;
        ctl_addr = '0;
        ctl_wdata = '0;
        lat = 2'h0;
        st_exp = 2'h0;
        error_cnt = 0;
        total_checks = 0;
        void'($urandom(44));
        repeat (2) @(negedge clk_sys);
        chk("ready in reset", 0, ctl_ready);
        rst_n = 1'b1;
        @(negedge clk_sys);
        chk("ready", 1, ctl_ready);
        for (int i = 0; i < 24; i++) begin
            hb_sel = 1'($urandom);
            hb_addr = (i % 3 == 0) ? OFS_ADDR_EXT : (i % 3 == 1) ? OFS_CSR3 : HB_ADDR_W'($urandom);
            dma_grant_in = 1'($urandom);
            @(negedge clk_sys);
            chk("dma_grant_line", dma_grant_in, dma_grant_line);
            chk("dma_request_line", 0, dma_request_line);
            chk("sel_addr_ext", hb_sel && hb_addr == OFS_ADDR_EXT, sel_addr_ext);
            chk("sel_csr3", hb_sel && hb_addr == OFS_CSR3, sel_csr3);
        end
        foreach (cor[i]) op(cor[i][23], cor[i][ADDR_W-1:0], cor[i][22]);
        err_en = 1'b1;
        op(1'b0, 22'h000302, 1'b1);
        err_en = 1'b0;
        ctl_status_clr = 1'b1;
        @(negedge clk_sys);
        ctl_status_clr = 1'b0;
        st_exp = 2'h0;
        @(negedge clk_sys);
        chk("status cleared", st_exp, ctl_status);
        for (int t = 0; t < 40; t++) begin
            rw = 1'($urandom);
            lat = 2'($urandom);
            a0 = ADDR_W'($urandom_range(0, 255) * 2);
            n = $urandom_range(1, 5);
            for (int k = 0; k < n; k++) op(rw, a0 + ADDR_W'(2 * k), k == n - 1);
        end
        final_report();
    end
endmodule : tb

// *** src/cwb_bridge.sv ***
// cwb_bridge: 16-bit controller DMA words to a 32-bit cache memory port
// assumes one clock, controller requests only while ctl_ready is high
//
// Behaviour
// - never raise the DMA request on the host bus; pass the grant on.
// - decode selects for the address extension and third control-status registers.
// - manage buffering between paths and carry address and control to the cache.
// - odd start or finish word address uses a single 16-bit cache transfer; code narrows an odd start or even last word, not a paired odd last.
// - each data request carries a 22-bit address; bit 0 is unused.
// - report detected error conditions back to the port adapter side.
// - reads fetch 32 bits into two buffers, delivered one after the other.
// - writes fill first then second buffer, then start one cache write.
`timescale 1ns/100ps
module cwb_bridge #(
    parameter int ADDR_W = cwb_pkg::ADDR_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // host system bus
    input wire logic dma_grant_in,
    output logic dma_grant_line,
    output logic dma_request_line,
    input wire logic hb_sel,
    input wire logic [cwb_pkg::HB_ADDR_W-1:0] hb_addr,
    output logic sel_addr_ext,
    output logic sel_csr3,
    // controller word port
    input wire logic ctl_req,
    input wire logic ctl_write,
    input wire logic ctl_last,
    input wire logic [ADDR_W-1:0] ctl_addr,
    input wire logic [cwb_pkg::NARROW_W-1:0] ctl_wdata,
    output logic ctl_ready,
    output logic ctl_ack,
    output logic ctl_rvalid,
    output logic [cwb_pkg::NARROW_W-1:0] ctl_rdata,
    input wire logic ctl_status_clr,
    output logic [1:0] ctl_status,
    // cache memory port
    output logic cache_req,
    output logic cache_we,
    output logic [1:0] cache_half,
    output logic [ADDR_W-1:0] cache_addr,
    output logic [cwb_pkg::WIDE_W-1:0] cache_wdata,
    input wire logic cache_ack,
    input wire logic cache_err,
    input wire logic [cwb_pkg::WIDE_W-1:0] cache_rdata
);
    import cwb_pkg::*;

    // =====================================================================
    // parameter check
    if (ADDR_W < 3) begin : g_bad_width
        $error("cwb_bridge: ADDR_W must be at least 3");
    end

    // =====================================================================
    // declarations
    cwb_buf_if bif ();
    cwb_state_e state, next_state;
    logic next_grant, next_sel_ext, next_sel_csr3;
    logic next_ready, next_ack, next_rvalid;
    logic [NARROW_W-1:0] next_rdata;
    logic [1:0] next_status;
    logic next_cache_req, next_cache_we;
    logic [1:0] next_half;
    logic [ADDR_W-1:0] next_cache_addr;
    logic have_a, next_have_a;
    logic pair_valid, next_pair_valid;
    logic rd_sel_hi, next_rd_sel_hi;
    logic [ADDR_W-1:0] pend_addr, next_pend_addr;
    logic set_mem, set_seq;

    // address of the odd partner word of an even pair
    function automatic logic [ADDR_W-1:0] odd_partner(input logic [ADDR_W-1:0] a);
        odd_partner = {a[ADDR_W-1:2], 2'h2};
    endfunction : odd_partner
    // address of the 32-bit cache word that holds a narrow word; bits 1:0 are zero
    function automatic logic [ADDR_W-1:0] cache_word(input logic [ADDR_W-1:0] a);
        cache_word = {a[ADDR_W-1:2], 2'h0};
    endfunction : cache_word
    // two narrow word addresses name the same word; bit 0 carries nothing
    function automatic logic same_word(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        same_word = (a[ADDR_W-1:1] == b[ADDR_W-1:1]);
    endfunction : same_word

    // =====================================================================
    // data buffers
    cwb_data_buf u_buf (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bif(bif.store)
    );
    assign cache_wdata = {bif.hi, bif.lo};
    assign bif.in16 = ctl_wdata;
    assign bif.in32 = cache_rdata;

    // =====================================================================
    // host bus side: grant pass-through and register selection
    always_comb begin
        next_grant = dma_grant_in;
        next_sel_ext = hb_sel && (hb_addr == OFS_ADDR_EXT);
        next_sel_csr3 = hb_sel && (hb_addr == OFS_CSR3);
    end

    // =====================================================================
    // transfer sequencer: pairs narrow words into cache words and back
    always_comb begin
        next_state = state;
        next_ack = 1'b0;
        next_rvalid = 1'b0;
        next_rdata = ctl_rdata;
        next_cache_req = cache_req;
        next_cache_we = cache_we;
        next_half = cache_half;
        next_cache_addr = cache_addr;
        next_have_a = have_a;
        next_pair_valid = pair_valid;
        next_rd_sel_hi = rd_sel_hi;
        next_pend_addr = pend_addr;
        bif.load_lo = 1'b0;
        bif.load_hi = 1'b0;
        bif.load_word = 1'b0;
        set_mem = 1'b0;
        set_seq = 1'b0;
        case (state)
            CWB_ST_IDLE: begin
                if (ctl_req) begin
                    next_pair_valid = 1'b0;
                    if (ctl_write) begin
                        next_ack = 1'b1;
                        if (have_a && same_word(ctl_addr, pend_addr)) begin
                            // second word completes the pair: one wide write
                            bif.load_hi = 1'b1;
                            next_have_a = 1'b0;
                            next_state = CWB_ST_CACHE;
                            next_cache_req = 1'b1;
                            next_cache_we = 1'b1;
                            next_half = HALF_BOTH;
                            next_cache_addr = cache_word(pend_addr);
                        end else begin
                            set_seq = have_a;
                            if (!ctl_addr[ODD_BIT] && !ctl_last) begin
                                bif.load_lo = 1'b1;
                                next_have_a = 1'b1;
                                next_pend_addr = odd_partner(ctl_addr);
                            end else begin
                                // odd start or lone final word: narrow write
                                bif.load_hi = ctl_addr[ODD_BIT];
                                bif.load_lo = !ctl_addr[ODD_BIT];
                                next_have_a = 1'b0;
                                next_state = CWB_ST_CACHE;
                                next_cache_req = 1'b1;
                                next_cache_we = 1'b1;
                                next_half = ctl_addr[ODD_BIT] ? HALF_HI : HALF_LO;
                                next_cache_addr = cache_word(ctl_addr);
                            end
                        end
                    end else begin
                        set_seq = have_a;
                        next_have_a = 1'b0;
                        if (pair_valid && same_word(ctl_addr, pend_addr)) begin
                            // second half comes from the buffer, no cache cycle
                            next_rdata = bif.hi;
                            next_rvalid = 1'b1;
                        end else begin
                            next_state = CWB_ST_CACHE;
                            next_cache_req = 1'b1;
                            next_cache_we = 1'b0;
                            next_rd_sel_hi = ctl_addr[ODD_BIT];
                            next_pend_addr = odd_partner(ctl_addr);
                            next_cache_addr = cache_word(ctl_addr);
                            if (ctl_addr[ODD_BIT]) begin
                                next_half = HALF_HI;
                            end else if (ctl_last) begin
                                next_half = HALF_LO;
                            end else begin
                                next_half = HALF_BOTH;
                            end
                        end
                    end
                end
            end
            CWB_ST_CACHE: begin
                // hold address and control toward the cache until acknowledged
                if (cache_ack) begin
                    next_state = CWB_ST_IDLE;
                    next_cache_req = 1'b0;
                    set_mem = cache_err;
                    if (!cache_we) begin
                        bif.load_word = 1'b1;
                        next_rdata = rd_sel_hi ? cache_rdata[WIDE_W-1:NARROW_W]
                            : cache_rdata[NARROW_W-1:0];
                        next_rvalid = 1'b1;
                        // a narrow read keeps nothing for later delivery
                        next_pair_valid = (cache_half == HALF_BOTH) && !cache_err;
                    end
                end
            end
            default: begin
                next_state = CWB_ST_IDLE;
                next_cache_req = 1'b0;
            end
        endcase
        next_ready = (next_state == CWB_ST_IDLE);
        // a new error wins over a clear in the same cycle
        next_status = ctl_status & ~({2{ctl_status_clr}});
        next_status[ERR_MEM_BIT] = next_status[ERR_MEM_BIT] | set_mem;
        next_status[ERR_SEQ_BIT] = next_status[ERR_SEQ_BIT] | set_seq;
    end

    // =====================================================================
    // registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= CWB_ST_IDLE;
            dma_grant_line <= 1'b0;
            dma_request_line <= 1'b0;
            sel_addr_ext <= 1'b0;
            sel_csr3 <= 1'b0;
            ctl_ready <= 1'b0;
            ctl_ack <= 1'b0;
            ctl_rvalid <= 1'b0;
            ctl_rdata <= RST_WORD;
            ctl_status <= RST_STATUS;
            cache_req <= 1'b0;
            cache_we <= 1'b0;
            cache_half <= HALF_NONE;
            cache_addr <= '0;
            have_a <= 1'b0;
            pair_valid <= 1'b0;
            rd_sel_hi <= 1'b0;
            pend_addr <= '0;
        end else begin
            state <= next_state;
            dma_grant_line <= next_grant;
            dma_request_line <= 1'b0;
            sel_addr_ext <= next_sel_ext;
            sel_csr3 <= next_sel_csr3;
            ctl_ready <= next_ready;
            ctl_ack <= next_ack;
            ctl_rvalid <= next_rvalid;
            ctl_rdata <= next_rdata;
            ctl_status <= next_status;
            cache_req <= next_cache_req;
            cache_we <= next_cache_we;
            cache_half <= next_half;
            cache_addr <= next_cache_addr;
            have_a <= next_have_a;
            pair_valid <= next_pair_valid;
            rd_sel_hi <= next_rd_sel_hi;
            pend_addr <= next_pend_addr;
        end
    end

    // =====================================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_no_dma_req: assert property (##1 !dma_request_line) else $error("dma request raised");
    a_grant_pass: assert property (dma_grant_in |=> dma_grant_line)
        else $error("grant not passed on");
    a_decode_csr3: assert property (hb_sel && hb_addr == OFS_CSR3 |=> sel_csr3 && !sel_addr_ext)
        else $error("csr3 not selected");
    a_cache_hold: assert property (cache_req && !cache_ack |=> cache_req && $stable(cache_addr))
        else $error("cache request dropped early");
    a_odd_narrow: assert property ($rose(cache_req) && cache_half == HALF_HI |-> cache_addr[1] == 1'b0
        && $past(ctl_addr[ODD_BIT])) else $error("odd word not narrow");
    a_addr_bit0: assert property (cache_req |-> cache_addr[0] == 1'b0)
        else $error("address bit 0 used");
    a_err_report: assert property (cache_req && cache_ack && cache_err |=> ctl_status[ERR_MEM_BIT])
        else $error("cache error not reported");
    a_read_second: assert property (state == CWB_ST_IDLE && ctl_req && !ctl_write && pair_valid
        && same_word(ctl_addr, pend_addr) |=> ctl_rvalid && !cache_req && ctl_rdata == bif.hi)
        else $error("buffered half not delivered");
    a_write_pair: assert property ($rose(cache_req) && cache_we && cache_half == HALF_BOTH
        |-> $past(have_a) && ctl_ack && cache_wdata[NARROW_W-1:0] == $past(bif.lo))
        else $error("wide write before pair filled");
    a_discard_half: assert property (cache_req && cache_ack && !cache_we && cache_half != HALF_BOTH
        |=> ctl_rvalid && !pair_valid) else $error("unused half kept");

    c_wide_write: cover property ($rose(cache_req) && cache_we && cache_half == HALF_BOTH);
    c_narrow_write: cover property ($rose(cache_req) && cache_we && cache_half == HALF_HI);
    c_buffered_read: cover property (pair_valid && ctl_req && !ctl_write ##1 ctl_rvalid && !cache_req);
    c_mem_error: cover property (cache_ack && cache_err);
endmodule : cwb_bridge

// *** src/cwb_buf_if.sv ***
// cwb_buf_if: load strobes and contents of the two 16-bit data buffers
// assumes the owner and the store run on the same clock
`timescale 1ns/100ps
interface cwb_buf_if;
    import cwb_pkg::*;
    logic load_lo;
    logic load_hi;
    logic load_word;
    logic [NARROW_W-1:0] in16;
    logic [WIDE_W-1:0] in32;
    logic [NARROW_W-1:0] lo;
    logic [NARROW_W-1:0] hi;
    modport owner (output load_lo, output load_hi, output load_word, output in16,
        output in32, input lo, input hi);
    modport store (input load_lo, input load_hi, input load_word, input in16,
        input in32, output lo, output hi);
endinterface : cwb_buf_if

// *** src/cwb_data_buf.sv ***
// cwb_data_buf: the two 16-bit buffers between the wide and narrow paths
// assumes at most one of the load strobes is high in a cycle
`timescale 1ns/100ps
module cwb_data_buf (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // buffer access
    cwb_buf_if.store bif
);
    import cwb_pkg::*;
    logic [NARROW_W-1:0] next_lo;
    logic [NARROW_W-1:0] next_hi;

    // =====================================================================
    // buffer loading: a narrow word into one half, or a wide word into both
    always_comb begin
        next_lo = bif.lo;
        next_hi = bif.hi;
        if (bif.load_word) begin
            next_lo = bif.in32[NARROW_W-1:0];
            next_hi = bif.in32[WIDE_W-1:NARROW_W];
        end else if (bif.load_lo) begin
            next_lo = bif.in16;
        end else if (bif.load_hi) begin
            next_hi = bif.in16;
        end
    end

    // register the buffers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bif.lo <= RST_WORD;
            bif.hi <= RST_WORD;
        end else begin
            bif.lo <= next_lo;
            bif.hi <= next_hi;
        end
    end
endmodule : cwb_data_buf

// *** src/cwb_pkg.sv ***
// cwb_pkg: shared constants for the cache width bridge
// assumes a single 125 MHz clock domain and 16-bit controller words
package cwb_pkg;
    // =====================================================================
    // widths
    localparam int ADDR_W = 22;
    localparam int NARROW_W = 16;
    localparam int WIDE_W = 32;
    localparam int HB_ADDR_W = 18;
    // =====================================================================
    // host bus register selection offsets
    localparam logic [HB_ADDR_W-1:0] OFS_ADDR_EXT = 18'h00010;
    localparam logic [HB_ADDR_W-1:0] OFS_CSR3 = 18'h00012;
    // =====================================================================
    // cache half-word enables
    localparam logic [1:0] HALF_NONE = 2'h0;
    localparam logic [1:0] HALF_LO = 2'h1;
    localparam logic [1:0] HALF_HI = 2'h2;
    localparam logic [1:0] HALF_BOTH = 2'h3;
    // =====================================================================
    // field positions and reset values
    localparam int ODD_BIT = 1;
    localparam int ERR_MEM_BIT = 0;
    localparam int ERR_SEQ_BIT = 1;
    localparam logic [1:0] RST_STATUS = 2'h0;
    localparam logic [NARROW_W-1:0] RST_WORD = 16'h0000;
    localparam logic [ADDR_W-1:0] RST_ADDR = 22'h000000;
    typedef enum logic {CWB_ST_IDLE, CWB_ST_CACHE} cwb_state_e;
endpackage : cwb_pkg
